// ===== bench/stc_ext_src.sv
`timescale 1ns/100ps
// Far-side clock source: crystal on the oscillator pin or plain clock on the count pin
module stc_ext_src
#(parameter real HALF_NS = 40.0)
(
	input wire en_i,
	input wire osc_sel_i,
	output wire ext_pin_o,
	output wire osc_pin_o
);
reg ph = 1'b0;
// Stands low while disabled, so no stray edge appears between tests
always #(HALF_NS) ph = en_i ? ~ph : 1'b0;
// The unused pin idles low
assign ext_pin_o = ph & !osc_sel_i;
assign osc_pin_o = ph & osc_sel_i;
endmodule

// ===== bench/stc_timer_properties.sv
`timescale 1ns/100ps
`include "stc_consts.vh"
// Port-level checks; count writes and triggers excuse jumps in the count
module stc_chk
(
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] wb_adr_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire osc_input_pin_i,
	input wire osc_output_pin_o,
	input wire osc_amp_enable_o,
	input wire special_event_i,
	input wire overflow_flag_o,
	input wire timebase_valid_o,
	input wire [15:0] timebase_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
wire bus_wr = bus_req & wb_we_i;
property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
a_ack_one: assert property (p_ack_one) else $error("ack held too long");
property p_ack_req; bus_req |=> wb_ack_o; endproperty
a_ack_req: assert property (p_ack_req) else $error("ack missing");
property p_err; !wb_err_o; endproperty
a_err: assert property (p_err) else $error("err raised");
property p_amp_off; !osc_amp_enable_o |-> !osc_output_pin_o; endproperty
a_amp_off: assert property (p_amp_off) else $error("osc output while off");
property p_amp_inv; osc_amp_enable_o |-> osc_output_pin_o == !osc_input_pin_i; endproperty
a_amp_inv: assert property (p_amp_inv) else $error("osc output not inverted");
property p_step;
	$changed(timebase_o) && !$past(bus_wr) && !$past(special_event_i)
		|-> timebase_o == $past(timebase_o) + 16'h0001;
endproperty
a_step: assert property (p_step) else $error("count jumped");
property p_wrap;
	$past(timebase_o) == 16'hFFFF && timebase_o == 16'h0000 && !$past(bus_wr)
		&& !$past(special_event_i) |-> ##[0:1] overflow_flag_o;
endproperty
a_wrap: assert property (p_wrap) else $error("wrap left flag clear");
property p_sticky; $fell(overflow_flag_o) |-> $past(bus_wr && wb_adr_i == `STC_ADDR_STATUS);
endproperty
a_sticky: assert property (p_sticky) else $error("flag dropped alone");
property p_evt; special_event_i && timebase_valid_o && !bus_wr |=> timebase_o == 16'h0000;
endproperty
a_evt: assert property (p_evt) else $error("trigger did not clear count");
c_wrap: cover property ($past(timebase_o) == 16'hFFFF && timebase_o == 16'h0000);
c_evt: cover property (special_event_i && timebase_valid_o);
c_clr: cover property ($fell(overflow_flag_o));
endmodule
bind stc_timer stc_chk u_stc_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .osc_input_pin_i(osc_input_pin_i),
	.osc_output_pin_o(osc_output_pin_o), .osc_amp_enable_o(osc_amp_enable_o),
	.special_event_i(special_event_i), .overflow_flag_o(overflow_flag_o),
	.timebase_valid_o(timebase_valid_o), .timebase_o(timebase_o));

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`include "stc_consts.vh"
module tb_top;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic [7:0] adr = 8'h00;
logic [31:0] dat = 32'h0000_0000;
logic we = 1'b0;
logic cs = 1'b0;
logic sleep = 1'b0;
logic evt = 1'b0;
logic pen = 1'b0;
logic psel = 1'b0;
wire [31:0] rdat;
wire ack, ext_pin, osc_pin, flag, amp;
wire [15:0] cnt;
logic [15:0] t0, rd;
int err_count = 0;
int checks_done = 0;
// {control, sleep, source on, crystal pin, count gain over 256 cycles}
logic [18:0] rows [0:10] = '{{8'hC1, 3'h0, 8'h40}, {8'h11, 3'h0, 8'h20},
	{8'h21, 3'h0, 8'h10}, {8'h35, 3'h0, 8'h08}, {8'h30, 3'h0, 8'h00},
	{8'h01, 3'h4, 8'h00}, {8'h03, 3'h2, 8'h10}, {8'h13, 3'h2, 8'h08},
	{8'h0B, 3'h3, 8'h10}, {8'h07, 3'h6, 8'h10}, {8'h03, 3'h6, 8'h00}};
always #2.5 clk_i = ~clk_i;
stc_ext_src u_stc_ext_src (.en_i(pen), .osc_sel_i(psel), .ext_pin_o(ext_pin), .osc_pin_o(osc_pin));
stc_timer u_stc_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
	.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cs), .wb_stb_i(cs),
	.wb_ack_o(ack), .wb_err_o(), .sleep_i(sleep), .external_count_pin_i(ext_pin),
	.osc_input_pin_i(osc_pin), .osc_output_pin_o(), .osc_amp_enable_o(amp),
	.special_event_i(evt), .overflow_flag_o(flag), .timebase_valid_o(), .timebase_o(cnt));
task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
	checks_done++;
	if (seen !== exp)
	begin
		err_count++;
		$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
	end
endtask
// One classic cycle; held until ack is sampled, the watchdog bounds the wait
task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_i);
	cs <= 1'b1;
	we <= w;
	adr <= a;
	dat <= {24'h00_0000, d};
	do @(posedge clk_i); while (ack !== 1'b1);
	rd = rdat[15:0];
	cs <= 1'b0;
	we <= 1'b0;
endtask
task tally_and_finish;
	$display("checks %0d mismatches %0d", checks_done, err_count);
	if (err_count == 0 && checks_done > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
initial
begin
	repeat (20000) @(posedge clk_i);
	err_count++;
	tally_and_finish();
end
////////////////////////////////////////////////////////////////////////////////
initial
begin
	repeat (12) @(posedge clk_i);
	rst_i <= 1'b0;
	bus(1'b0, `STC_ADDR_CONTROL, 8'h00);
	chk("ctrl reset", rd, 16'h0000);
	// Rate is measured over a fixed span, so the sync latency drops out
	foreach (rows[i])
	begin
		sleep <= rows[i][10];
		pen <= rows[i][9];
		psel <= rows[i][8];
		bus(1'b1, `STC_ADDR_CONTROL, rows[i][18:11]);
		bus(1'b0, `STC_ADDR_CONTROL, 8'h00);
		chk("control", rd, {8'h00, rows[i][18:11] & 8'h3F});
		chk("amp", {15'h0000, amp}, {15'h0000, rows[i][14]});
		repeat (40) @(posedge clk_i);
		t0 = cnt;
		repeat (256) @(posedge clk_i);
		chk("rate", cnt - t0, {8'h00, rows[i][7:0]});
		$display("row %0d done", i);
	end
	pen <= 1'b0;
	sleep <= 1'b0;
	bus(1'b1, `STC_ADDR_CONTROL, 8'h00);
	bus(1'b1, `STC_ADDR_COUNT_HIGH, 8'hFF);
	bus(1'b1, `STC_ADDR_COUNT_LOW, 8'hFF);
	chk("preload", cnt, 16'hFFFF);
	bus(1'b1, `STC_ADDR_CONTROL, 8'h01);
	repeat (12) @(posedge clk_i);
	chk("flag", {15'h0000, flag}, 16'h0001);
	bus(1'b1, `STC_ADDR_CONTROL, 8'h00);
	bus(1'b1, `STC_ADDR_STATUS, 8'h01);
	bus(1'b0, `STC_ADDR_STATUS, 8'h00);
	chk("flag clear", rd & 16'h0001, 16'h0000);
	chk("timebase timer", rd & 16'h0002, 16'h0002);
	bus(1'b1, `STC_ADDR_COUNT_LOW, 8'h55);
	evt <= 1'b1;
	@(posedge clk_i);
	evt <= 1'b0;
	@(posedge clk_i);
	chk("trigger", cnt, 16'h0000);
	bus(1'b0, 8'h40, 8'h00);
	chk("unmapped", rd, 16'h0000);
	$display("wrap and trigger done");
	// Load in the safe order, then read high, low, high as software would
	bus(1'b1, `STC_ADDR_COUNT_LOW, 8'h00);
	bus(1'b1, `STC_ADDR_COUNT_HIGH, 8'h12);
	bus(1'b1, `STC_ADDR_COUNT_LOW, 8'h34);
	bus(1'b0, `STC_ADDR_COUNT_HIGH, 8'h00);
	t0 = {rd[7:0], 8'h00};
	bus(1'b0, `STC_ADDR_COUNT_LOW, 8'h00);
	t0[7:0] = rd[7:0];
	bus(1'b0, `STC_ADDR_COUNT_HIGH, 8'h00);
	chk("high reread", {8'h00, rd[7:0]}, 16'h0012);
	chk("pair read", t0, 16'h1234);
	// Asynchronous counter mode is no time base
	bus(1'b1, `STC_ADDR_CONTROL, 8'h06);
	bus(1'b0, `STC_ADDR_STATUS, 8'h00);
	chk("timebase async", rd & 16'h0002, 16'h0000);
	$display("byte access done");
	bus(1'b1, `STC_ADDR_CONTROL, 8'h3F);
	rst_i <= 1'b1;
	repeat (2) @(posedge clk_i);
	rst_i <= 1'b0;
	bus(1'b0, `STC_ADDR_CONTROL, 8'h00);
	chk("ctrl rerst", rd, 16'h0000);
	$display("reset done");
	tally_and_finish();
end
endmodule

// ===== design/stc_consts.vh
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH
// Register byte addresses (word aligned)
`define STC_ADDR_CONTROL 8'h10
`define STC_ADDR_COUNT_LOW 8'h14
`define STC_ADDR_COUNT_HIGH 8'h18
`define STC_ADDR_STATUS 8'h1C
// Control field positions
`define STC_BIT_RUN 0
`define STC_BIT_SOURCE 1
`define STC_BIT_SYNC_BYPASS 2
`define STC_BIT_OSC_ENABLE 3
`define STC_BIT_PRESCALE_LO 4
`define STC_BIT_PRESCALE_HI 5
// Status field positions
`define STC_BIT_OVERFLOW 0
`define STC_BIT_TIMEBASE_OK 1
// Reset values
`define STC_CONTROL_RESET 6'h00
`define STC_COUNT_RESET 16'h0000
// Core clock divided by four in timer mode
`define STC_INT_DIV 2'h3
`endif

// ===== design/stc_edge_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser followed by a rising-edge pulse generator
module stc_edge_sync
(
	input wire clk_i,
	input wire rst_i,
	input wire async_i,
	output wire level_o,
	output wire rise_o
);
	reg stage1;
	reg stage2;
	reg stage3;
	// First stage feeds only the second stage
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end
	assign level_o = stage2;
	assign rise_o = stage2 & ~stage3;
endmodule

// ===== design/stc_timer.v
`timescale 1ns/100ps
`include "stc_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module stc_timer
(
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg wb_ack_o,
	output wire wb_err_o,
	input wire sleep_i,
	input wire external_count_pin_i,
	input wire osc_input_pin_i,
	output wire osc_output_pin_o,
	output wire osc_amp_enable_o,
	input wire special_event_i,
	output wire overflow_flag_o,
	output wire timebase_valid_o,
	output wire [15:0] timebase_o
);
	////////////////////////////////////////////////////////////////////////////
	reg [5:0] control;
	reg [7:0] count_low;
	reg [7:0] count_high;
	reg overflow_flag;
	reg [1:0] int_div;
	reg [2:0] prescale;
	reg armed;
	reg prescaler_clear;
	reg async_prev;
	wire run = control[`STC_BIT_RUN];
	wire source_ext = control[`STC_BIT_SOURCE];
	wire sync_bypass = control[`STC_BIT_SYNC_BYPASS];
	wire osc_enable = control[`STC_BIT_OSC_ENABLE];
	wire [1:0] prescale_sel = control[`STC_BIT_PRESCALE_HI:`STC_BIT_PRESCALE_LO];
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_control = bus_wr & (wb_adr_i == `STC_ADDR_CONTROL);
	wire wr_low = bus_wr & (wb_adr_i == `STC_ADDR_COUNT_LOW);
	wire wr_high = bus_wr & (wb_adr_i == `STC_ADDR_COUNT_HIGH);
	wire wr_status = bus_wr & (wb_adr_i == `STC_ADDR_STATUS);
	wire wr_count = wr_low | wr_high;
	wire async_mode = source_ext & sync_bypass;
	////////////////////////////////////////////////////////////////////////////
	// Pin selection; the amplifier drives the output pin only while enabled
	wire ext_raw = osc_enable ? osc_input_pin_i : external_count_pin_i;
	assign osc_amp_enable_o = osc_enable;
	assign osc_output_pin_o = osc_enable & ~osc_input_pin_i;
	// Raw input in the core domain, used for low-level arming and prescaling
	wire ext_level;
	wire ext_rise;
	stc_edge_sync u_pin_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(ext_raw),
		.level_o(ext_level),
		.rise_o(ext_rise)
	);
	////////////////////////////////////////////////////////////////////////////
	// Arm once the pin is sampled low while enabled in counter mode
	always @(posedge clk_i)
	begin
		if (rst_i)
			armed <= 1'b0;
		else if (!(run && source_ext))
			armed <= 1'b0;
		else if (!ext_level)
			armed <= 1'b1;
	end
	// Prescaler counts rising edges of the pin even in sleep, and is cleared
	// on count writes. A pure ripple chain is modelled as a counter clocked
	// by edge pulses so the design keeps a single clock.
	always @(posedge clk_i)
	begin
		if (rst_i)
			prescale <= 3'h0;
		else if (wr_count)
			prescale <= 3'h0;
		else if (ext_rise && armed)
			prescale <= prescale + 3'h1;
	end
	reg presc_out;
	always @*
	begin
		case (prescale_sel)
			2'b00: presc_out = ext_level & armed;
			2'b01: presc_out = prescale[0];
			2'b10: presc_out = prescale[1];
			default: presc_out = prescale[2];
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// Synchronised path: the prescaler output gets its own two flops
	wire sync_rise;
	stc_edge_sync u_presc_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(presc_out),
		.level_o(),
		.rise_o(sync_rise)
	);
	// Asynchronous path: edge taken straight from the prescaler output
	always @(posedge clk_i)
	begin
		if (rst_i)
			async_prev <= 1'b0;
		else
			async_prev <= presc_out;
	end
	wire async_rise = presc_out & ~async_prev;
	// Internal divide by four of the core clock
	always @(posedge clk_i)
	begin
		if (rst_i)
			int_div <= 2'h0;
		else if (wr_count)
			int_div <= 2'h0;
		else
			int_div <= int_div + 2'h1;
	end
	wire int_tick = (int_div == `STC_INT_DIV);
	reg int_tick_pre;
	// Internal prescaler; sync bit has no say here
	reg [2:0] int_presc;
	always @(posedge clk_i)
	begin
		if (rst_i)
			int_presc <= 3'h0;
		else if (wr_count)
			int_presc <= 3'h0;
		else if (int_tick && run && !source_ext)
			int_presc <= int_presc + 3'h1;
	end
	always @*
	begin
		case (prescale_sel)
			2'b00: int_tick_pre = int_tick;
			2'b01: int_tick_pre = int_tick & int_presc[0];
			2'b10: int_tick_pre = int_tick & (int_presc[1:0] == 2'b11);
			default: int_tick_pre = int_tick & (int_presc == 3'b111);
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// Increment selection by source and sync mode
	reg inc;
	always @*
	begin
		if (!run)
			inc = 1'b0;
		else if (!source_ext)
			inc = int_tick_pre & ~sleep_i;
		else if (sync_bypass)
			inc = async_rise;
		else
			inc = sync_rise & ~sleep_i;
	end
	// Count register: write beats compare trigger, which beats increment
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_low <= 8'h00;
			count_high <= 8'h00;
		end
		else if (wr_count)
		begin
			if (wr_low)
				count_low <= wb_dat_i[7:0];
			if (wr_high)
				count_high <= wb_dat_i[7:0];
		end
		else if (special_event_i && !async_mode)
		begin
			count_low <= 8'h00;
			count_high <= 8'h00;
		end
		else if (inc)
			{count_high, count_low} <= {count_high, count_low} + 16'h0001;
	end
	wire wrap = inc & ~wr_count & ~(special_event_i & ~async_mode)
		& ({count_high, count_low} == 16'hFFFF);
	// Overflow flag; a new wrap wins over a software clear
	always @(posedge clk_i)
	begin
		if (rst_i)
			overflow_flag <= 1'b0;
		else if (wrap)
			overflow_flag <= 1'b1;
		else if (wr_status && wb_dat_i[`STC_BIT_OVERFLOW])
			overflow_flag <= 1'b0;
	end
	assign overflow_flag_o = overflow_flag;
	assign timebase_valid_o = ~async_mode;
	assign timebase_o = {count_high, count_low};
	////////////////////////////////////////////////////////////////////////////
	// Control register; upper bits unimplemented
	always @(posedge clk_i)
	begin
		if (rst_i)
			control <= `STC_CONTROL_RESET;
		else if (wr_control)
			control <= wb_dat_i[5:0];
	end
	// Bus reply: ack registered one cycle after the request, reads come from registered count bytes,
	// which are always stable in the core domain
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
			begin
				if (wb_adr_i == `STC_ADDR_CONTROL)
					wb_dat_o <= {26'h000_0000, control};
				else if (wb_adr_i == `STC_ADDR_COUNT_LOW)
					wb_dat_o <= {24'h00_0000, count_low};
				else if (wb_adr_i == `STC_ADDR_COUNT_HIGH)
					wb_dat_o <= {24'h00_0000, count_high};
				else if (wb_adr_i == `STC_ADDR_STATUS)
					wb_dat_o <= {30'h0000_0000, ~async_mode, overflow_flag};
				else
					wb_dat_o <= 32'h0000_0000;
			end
		end
	end
	assign wb_err_o = 1'b0;
endmodule
